//--- slvm_delay.sv
`timescale 1ns/1ps
module slvm_delay (
	input wire logic mclk,
	input wire logic rst,
	input wire logic run,
	input wire logic indicator,
	input wire logic [slvm_pkg::SLVM_CNT_W-1:0] delay_cycles,
	output logic expire
);
	import slvm_pkg::*;
	slvm_state_e state;
	logic [SLVM_CNT_W-1:0] count;

	// Counts the settling delay while the indicator stays high; one pulse on expiry.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= SLVM_IDLE;
			count <= '0;
			expire <= 1'b0;
		end else begin
			expire <= 1'b0;
			if (!run || !indicator) begin
				state <= SLVM_IDLE;
				count <= '0;
			end else begin
				case (state)
					SLVM_IDLE: begin
						state <= SLVM_COUNT;
						count <= '0;
					end
					SLVM_COUNT: begin
						if (count >= delay_cycles - 1'b1) begin
							state <= SLVM_DONE;
							expire <= 1'b1;
						end else begin
							count <= count + 1'b1;
						end
					end
					SLVM_DONE: state <= SLVM_DONE;
					default: state <= SLVM_IDLE;
				endcase
			end
		end
	end
endmodule : slvm_delay

//--- slvm_pkg.sv
package slvm_pkg;
	// Register map of the plain register port.
	localparam logic [3:0] SLVM_ADDR_CONTROL = 4'h0;
	localparam logic [3:0] SLVM_ADDR_IRQ_STATUS = 4'h1;
	localparam logic [3:0] SLVM_ADDR_IRQ_MASK = 4'h2;
	localparam logic [3:0] SLVM_ADDR_CPU_CONTROL = 4'h3;
	// Control register field positions.
	localparam int SLVM_BIT_INDICATOR = 5;
	localparam int SLVM_BIT_DETECTOR_ON = 4;
	localparam int SLVM_BIT_BANDGAP_ON = 3;
	localparam int SLVM_THRESH_MSB = 2;
	localparam logic [7:0] SLVM_CONTROL_RESET = 8'h00;
	localparam logic [7:0] SLVM_CONTROL_WMASK = 8'h1f;
	// Processor interrupt control register bits.
	localparam int SLVM_BIT_GIE = 0;
	localparam int SLVM_BIT_LVIE = 1;
	localparam int SLVM_BIT_REQ = 2;
	// Interrupt status and mask bits.
	localparam int SLVM_EV_REQ_SET = 0;
	localparam int SLVM_EV_INDICATOR_RISE = 1;
	localparam int SLVM_EV_WAKE = 2;
	localparam int SLVM_NUM_EVENTS = 3;
	// Settling delay from indicator high to request flag, in ns.
	localparam int SLVM_CLK_MHZ = 40;
	localparam int SLVM_DELAY_NS = 1000;
	localparam int SLVM_DELAY_CYCLES = (SLVM_DELAY_NS * SLVM_CLK_MHZ + 999) / 1000;
	localparam int SLVM_CNT_W = 16;
	// Detection levels in tens of millivolts, by threshold code.
	localparam logic [8:0] SLVM_LEVEL_TABLE [8] = '{
		9'd200, 9'd220, 9'd240, 9'd270, 9'd300, 9'd330, 9'd360, 9'd400
	};
	// Delay state machine.
	typedef enum logic [1:0] {
		SLVM_IDLE = 2'b00,
		SLVM_COUNT = 2'b01,
		SLVM_DONE = 2'b11
	} slvm_state_e;
endpackage : slvm_pkg

//--- slvm_supply_model.sv
`timescale 1ns/1ps
// Behavioural comparator on the analog side.
module slvm_supply_model (
	input wire logic detector_power,
	input wire logic [8:0] threshold_level,
	input wire logic [8:0] supply_level,
	output logic comparator_low
);
	// An unpowered comparator never reports a low supply; toggles pass straight on.
	assign comparator_low = detector_power && (supply_level < threshold_level);
endmodule : slvm_supply_model

//--- slvm_sync.sv
`timescale 1ns/1ps
module slvm_sync (
	input wire logic mclk,
	input wire logic rst,
	input wire logic async_in,
	output logic sync_out
);
	import slvm_pkg::*;
	logic stage1;

	// Two flip-flops; only the second one is seen by logic.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stage1 <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : slvm_sync

//--- slvm_top.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Request flag holds until serviced or cleared.
// - Request flag rising edge wakes the device.
// - Interrupt return restores global enable; subroutine return not.
// - Three-bit code selects one of eight levels.
// - Bit five reads one while supply low.
// - Bit four switches detector on or off.
// - Bandgap on for detector, brownout or buffer.
// - Bits seven and six read zero.
// - Sleep forces the detector off.
// - Indicator toggles pass through unfiltered.
// - Request flag sets after fixed delay.
// - Request flag set wakes from idle.
// - Service needs both enables and free stack.
// - Service clears request flag and global enable.
module slvm_top #(
	parameter logic [slvm_pkg::SLVM_CNT_W-1:0] DELAY_CYCLES =
		slvm_pkg::SLVM_CNT_W'(slvm_pkg::SLVM_DELAY_CYCLES)
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic comparator_low,
	input wire logic sleep_mode,
	input wire logic idle_mode,
	input wire logic brownout_reset_on,
	input wire logic stack_full,
	input wire logic irq_ack,
	input wire logic return_from_interrupt,
	input wire logic return_from_subroutine,
	output logic detector_power,
	output logic bandgap_power,
	output logic [8:0] threshold_level,
	output logic irq_take,
	output logic wake,
	output logic irq
);
	import slvm_pkg::*;

	// Register state and flags.
	logic [7:0] control;
	logic supply_low_indicator;
	logic supply_low_irq_request;
	logic supply_low_irq_enable;
	logic global_irq_enable;
	logic [SLVM_NUM_EVENTS-1:0] irq_status;
	logic [SLVM_NUM_EVENTS-1:0] irq_mask;
	// Synchronised pins.
	logic comp_sync;
	logic sleep_sync;
	logic idle_sync;
	logic lvr_sync;
	// Internal control and edge history.
	logic detector_run;
	logic delay_expire;
	logic request_prev;
	logic indicator_prev;
	logic service;
	// Decoded register strobes and event vectors.
	logic wr_control;
	logic wr_cpu;
	logic wr_mask;
	logic rd_status;
	logic [SLVM_NUM_EVENTS-1:0] events;
	logic [SLVM_NUM_EVENTS-1:0] next_irq_status;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers for the analog result and the power-mode straps.
	// These inputs come from other domains, so each passes two flip-flops first.
	slvm_sync u_sync_comp (
		.mclk(mclk),
		.rst(rst),
		.async_in(comparator_low),
		.sync_out(comp_sync)
	);
	slvm_sync u_sync_sleep (
		.mclk(mclk),
		.rst(rst),
		.async_in(sleep_mode),
		.sync_out(sleep_sync)
	);
	slvm_sync u_sync_idle (
		.mclk(mclk),
		.rst(rst),
		.async_in(idle_mode),
		.sync_out(idle_sync)
	);
	slvm_sync u_sync_lvr (
		.mclk(mclk),
		.rst(rst),
		.async_in(brownout_reset_on),
		.sync_out(lvr_sync)
	);

	// The detector only runs when enabled and the device is awake.
	// Sleep is seen after its synchroniser, so the detector drops two cycles late.
	assign detector_run = control[SLVM_BIT_DETECTOR_ON] & ~sleep_sync;

	////////////////////////////////////////////////////////////////////////////
	// Decoded register strobes.
	assign wr_control = reg_write && (reg_addr == SLVM_ADDR_CONTROL);
	assign wr_cpu = reg_write && (reg_addr == SLVM_ADDR_CPU_CONTROL);
	assign wr_mask = reg_write && (reg_addr == SLVM_ADDR_IRQ_MASK);
	assign rd_status = reg_read && (reg_addr == SLVM_ADDR_IRQ_STATUS);

	// Control register; only threshold, bandgap and detector bits are writable.
	// The indicator bit is read-only, so the write mask drops whatever lands on it.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			control <= SLVM_CONTROL_RESET;
		end else if (wr_control) begin
			control <= reg_wdata & SLVM_CONTROL_WMASK;
		end
	end

	// Indicator follows the comparator with no filtering, forced low when off.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			supply_low_indicator <= 1'b0;
		end else begin
			supply_low_indicator <= detector_run & comp_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Settling delay from indicator high to the request flag.
	// It counts system clocks, so its length follows the clock rate.
	slvm_delay u_delay (
		.mclk(mclk),
		.rst(rst),
		.run(detector_run),
		.indicator(supply_low_indicator),
		.delay_cycles(DELAY_CYCLES),
		.expire(delay_expire)
	);

	// Interrupt is taken only with both enables, a pending flag and stack room.
	// The acknowledge stands for the core being ready to branch to the vector.
	assign service = supply_low_irq_request & supply_low_irq_enable & global_irq_enable
		& ~stack_full & irq_ack;

	// Request flag: set by expiry, kept until service or software clear; set wins.
	// Software may preset it before halting, so a later expiry makes no rising edge.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			supply_low_irq_request <= 1'b0;
		end else if (delay_expire) begin
			supply_low_irq_request <= 1'b1;
		end else if (wr_cpu) begin
			supply_low_irq_request <= reg_wdata[SLVM_BIT_REQ];
		end else if (service) begin
			supply_low_irq_request <= 1'b0;
		end
	end

	// Local enable is plain software state; clearing it never clears the flag.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			supply_low_irq_enable <= 1'b0;
		end else if (wr_cpu) begin
			supply_low_irq_enable <= reg_wdata[SLVM_BIT_LVIE];
		end
	end

	// Global enable: cleared on service, set by interrupt return or a software write.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			global_irq_enable <= 1'b0;
		end else if (service) begin
			global_irq_enable <= 1'b0;
		end else if (return_from_interrupt) begin
			global_irq_enable <= 1'b1;
		end else if (return_from_subroutine) begin
			global_irq_enable <= global_irq_enable;
		end else if (wr_cpu) begin
			global_irq_enable <= reg_wdata[SLVM_BIT_GIE];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Edge history for wake-up and event detection.
	// Both history bits reset to the idle level of their flags, so no false edge follows reset.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			request_prev <= 1'b0;
			indicator_prev <= 1'b0;
		end else begin
			request_prev <= supply_low_irq_request;
			indicator_prev <= supply_low_indicator;
		end
	end

	// Wake pulse on a rising request flag, regardless of enables.
	// While the core is running the pulse would mean nothing, so it is dropped.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wake <= 1'b0;
		end else begin
			wake <= supply_low_irq_request & ~request_prev & (sleep_sync | idle_sync);
		end
	end

	// Service strobe towards the processor core.
	// The cleared global enable keeps this to one pulse per service.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_take <= 1'b0;
		end else begin
			irq_take <= service;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sticky status events, cleared by a read; a new event wins over the clear.
	assign events[SLVM_EV_REQ_SET] = supply_low_irq_request & ~request_prev;
	assign events[SLVM_EV_INDICATOR_RISE] = supply_low_indicator & ~indicator_prev;
	// Wake is an event of its own, so software can tell why the core woke.
	assign events[SLVM_EV_WAKE] = wake;

	// Status after this edge: a read clears, but an event of the same cycle still lands.
	always_comb begin
		if (rd_status) begin
			next_irq_status = events;
		end else begin
			next_irq_status = irq_status | events;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_status <= '0;
		end else begin
			irq_status <= next_irq_status;
		end
	end

	// Mask register; its bits have the layout of the status bits.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_mask <= '0;
		end else if (wr_mask) begin
			irq_mask <= reg_wdata[SLVM_NUM_EVENTS-1:0];
		end
	end

	// Level interrupt output, built from the status as it stands after this edge.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_irq_status & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Analog controls, registered.
	// The code is decoded here so the comparator always sees a settled level.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			detector_power <= 1'b0;
			bandgap_power <= 1'b0;
			threshold_level <= SLVM_LEVEL_TABLE[0];
		end else begin
			detector_power <= detector_run;
			bandgap_power <= detector_run | lvr_sync | control[SLVM_BIT_BANDGAP_ON];
			threshold_level <= SLVM_LEVEL_TABLE[control[SLVM_THRESH_MSB:0]];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the read strobe; unmapped reads give zero.
	// The two top control bits are tied to zero and the indicator sits in bit five.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			case (reg_addr)
				SLVM_ADDR_CONTROL: begin
					reg_rdata <= {2'b00, supply_low_indicator, control[4:0]};
				end
				SLVM_ADDR_IRQ_STATUS: reg_rdata <= {5'h00, irq_status};
				SLVM_ADDR_IRQ_MASK: reg_rdata <= {5'h00, irq_mask};
				SLVM_ADDR_CPU_CONTROL: begin
					reg_rdata <= {5'h00, supply_low_irq_request, supply_low_irq_enable,
						global_irq_enable};
				end
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule : slvm_top

//--- slvm_top_sva.sv
`timescale 1ns/1ps
////////////////////////////////////////
// Watches the register port and the power and interrupt outputs.
module slvm_chk
	import slvm_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic sleep_mode,
	input wire logic stack_full,
	input wire logic detector_power,
	input wire logic bandgap_power,
	input wire logic [8:0] threshold_level,
	input wire logic irq_take,
	input wire logic wake
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// A software write to the control register.
	sequence ctrl_wr;
		reg_write && reg_addr == SLVM_ADDR_CONTROL;
	endsequence
	AST_RDATA_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	AST_CTRL_TOP: assert property ($past(reg_read) && $past(reg_addr) == SLVM_ADDR_CONTROL |-> reg_rdata[7:6] == 2'b00)
		else $error("control top bits not zero");
	AST_THRESH: assert property (ctrl_wr ##2 1'b1 |-> threshold_level == SLVM_LEVEL_TABLE[$past(reg_wdata[2:0], 2)])
		else $error("threshold level does not match code");
	AST_DET_OFF: assert property (ctrl_wr ##0 !reg_wdata[SLVM_BIT_DETECTOR_ON] |-> ##2 !detector_power)
		else $error("detector powered after disable");
	AST_BANDGAP: assert property (ctrl_wr ##0 reg_wdata[SLVM_BIT_BANDGAP_ON] |-> ##2 bandgap_power)
		else $error("bandgap off with buffer enabled");
	AST_SLEEP_OFF: assert property (sleep_mode [*5] |-> !detector_power)
		else $error("detector powered in sleep");
	AST_TAKE_STACK: assert property (stack_full [*4] |-> !irq_take)
		else $error("interrupt taken with full stack");
	AST_TAKE_PULSE: assert property (irq_take |=> !irq_take)
		else $error("service repeated without new request");
	AST_WAKE_PULSE: assert property (wake |=> !wake)
		else $error("wake longer than one cycle");
endmodule : slvm_chk

bind slvm_top slvm_chk u_slvm_chk (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.sleep_mode(sleep_mode), .stack_full(stack_full), .detector_power(detector_power),
	.bandgap_power(bandgap_power), .threshold_level(threshold_level), .irq_take(irq_take),
	.wake(wake));

//--- test_slvm_top.sv
`timescale 1ns/1ps
////////////////////////////////////////
module test_slvm_top;
	import slvm_pkg::*;
	localparam logic [15:0] DLY = 16'h0004;
	logic mclk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
	logic sleep_mode = 1'b0, idle_mode = 1'b0, brownout_reset_on = 1'b0, stack_full = 1'b0;
	logic irq_ack = 1'b0, return_from_interrupt = 1'b0, return_from_subroutine = 1'b0;
	logic [8:0] supply_level = 9'h1c2, threshold_level;
	logic comparator_low, detector_power, bandgap_power, irq_take, wake, irq;
	int failures = 0, cmp_count = 0, cyc = 0, n = 0;
	slvm_top #(.DELAY_CYCLES(DLY)) u_slvm_top (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.comparator_low(comparator_low), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
		.brownout_reset_on(brownout_reset_on), .stack_full(stack_full), .irq_ack(irq_ack),
		.return_from_interrupt(return_from_interrupt),
		.return_from_subroutine(return_from_subroutine), .detector_power(detector_power),
		.bandgap_power(bandgap_power), .threshold_level(threshold_level), .irq_take(irq_take),
		.wake(wake), .irq(irq));
	slvm_supply_model u_slvm_supply_model (.detector_power(detector_power),
		.threshold_level(threshold_level), .supply_level(supply_level),
		.comparator_low(comparator_low));
	// Clock generation.
	initial forever #12.5 mclk = ~mclk;
	// Cuts a hang short.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			wrap_up();
		end
	end
	// Compares and counts.
	task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
		cmp_count++;
		if (exp !== got) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// Bus cycles and waits.
	task automatic clk(input int k);
		repeat (k) @(posedge mclk);
	endtask : clk
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
		@(posedge mclk);
	endtask : wr
	task automatic rd(input logic [3:0] a);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge mclk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
		@(posedge mclk);
	endtask : rd
	// Scenarios.
	task automatic t_reset;
		rd(SLVM_ADDR_CONTROL);
		chk("control", 9'h000, {1'b0, d});
		chk("level", 9'd200, threshold_level);
		wr(4'h9, 8'hff);
		rd(4'h9);
		chk("unmapped", 9'h000, {1'b0, d});
	endtask : t_reset
	task automatic t_codes;
		int lv[8] = '{200, 220, 240, 270, 300, 330, 360, 400};
		for (int c = 0; c < 8; c++) begin
			wr(SLVM_ADDR_CONTROL, 8'he0 | 8'(c));
			clk(2);
			chk("level", 9'(lv[c]), threshold_level);
			rd(SLVM_ADDR_CONTROL);
			chk("control", 9'(c), {1'b0, d});
		end
	endtask : t_codes
	task automatic t_power;
		chk("bandgap", 0, bandgap_power);
		wr(SLVM_ADDR_CONTROL, 8'h04);
		brownout_reset_on <= 1'b1;
		clk(5);
		chk("bandgap", 1, bandgap_power);
		chk("detector", 0, detector_power);
		brownout_reset_on <= 1'b0;
		wr(SLVM_ADDR_CONTROL, 8'h14);
		clk(5);
		chk("detector", 1, detector_power);
		chk("bandgap", 1, bandgap_power);
		wr(SLVM_ADDR_CONTROL, 8'h1c);
		rd(SLVM_ADDR_CONTROL);
		chk("control", 9'h01c, {1'b0, d});
	endtask : t_power
	task automatic t_low;
		wr(SLVM_ADDR_IRQ_MASK, 8'h01);
		rd(SLVM_ADDR_IRQ_STATUS);
		supply_level <= 9'd250;
		rd(SLVM_ADDR_CPU_CONTROL);
		n = 0;
		while (irq !== 1'b1 && n < 100) begin
			@(posedge mclk);
			n++;
		end
		chk("delay", 1, 9'(n >= DLY && n < DLY + 12));
		rd(SLVM_ADDR_CONTROL);
		chk("control", 9'h03c, {1'b0, d});
		rd(SLVM_ADDR_IRQ_STATUS);
		chk("status", 9'h003, {1'b0, d});
		chk("irq", 0, irq);
		clk(20);
		rd(SLVM_ADDR_CPU_CONTROL);
		chk("request", 1, d[SLVM_BIT_REQ]);
	endtask : t_low
	task automatic t_service;
		supply_level <= 9'd450;
		wr(SLVM_ADDR_CPU_CONTROL, 8'h07);
		stack_full <= 1'b1;
		irq_ack <= 1'b1;
		clk(8);
		rd(SLVM_ADDR_CPU_CONTROL);
		chk("request", 1, d[SLVM_BIT_REQ]);
		stack_full <= 1'b0;
		n = 0;
		while (irq_take !== 1'b1 && n < 20) begin
			@(posedge mclk);
			n++;
		end
		chk("take", 1, irq_take);
		irq_ack <= 1'b0;
		rd(SLVM_ADDR_CONTROL);
		chk("saved", 9'h01c, {1'b0, d});
		rd(SLVM_ADDR_CPU_CONTROL);
		chk("cpu", 9'h002, {1'b0, d});
		return_from_subroutine <= 1'b1;
		@(posedge mclk);
		return_from_subroutine <= 1'b0;
		rd(SLVM_ADDR_CPU_CONTROL);
		chk("cpu", 9'h002, {1'b0, d});
		return_from_interrupt <= 1'b1;
		@(posedge mclk);
		return_from_interrupt <= 1'b0;
		rd(SLVM_ADDR_CPU_CONTROL);
		chk("cpu", 9'h003, {1'b0, d});
		wr(SLVM_ADDR_CPU_CONTROL, 8'h00);
	endtask : t_service
	task automatic t_sleep;
		sleep_mode <= 1'b1;
		clk(6);
		supply_level <= 9'd250;
		clk(20);
		chk("detector", 0, detector_power);
		rd(SLVM_ADDR_CONTROL);
		chk("control", 9'h01c, {1'b0, d});
		rd(SLVM_ADDR_CPU_CONTROL);
		chk("request", 0, d[SLVM_BIT_REQ]);
	endtask : t_sleep
	task automatic t_idle;
		sleep_mode <= 1'b0;
		idle_mode <= 1'b1;
		n = 0;
		while (wake !== 1'b1 && n < 100) begin
			@(posedge mclk);
			n++;
		end
		chk("wake", 1, wake);
		supply_level <= 9'd450;
		clk(10);
		supply_level <= 9'd250;
		n = 0;
		repeat (30) begin
			@(posedge mclk);
			n += int'(wake === 1'b1);
		end
		chk("wakes", 0, 9'(n));
		idle_mode <= 1'b0;
	endtask : t_idle
	// Prints the verdict and ends the run.
	task automatic wrap_up;
		if (failures == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up
	// Main sequence.
	initial begin
		clk(8);
		rst <= 1'b0;
		@(posedge mclk);
		t_reset();
		t_codes();
		t_power();
		t_low();
		t_service();
		t_sleep();
		t_idle();
		wrap_up();
	end
endmodule : test_slvm_top
